/* rtl/eicfg_event_bank.sv */
// Extended interface configuration and event mask register bank
//
// Behaviour
// R01: Parallel I/O mode: each config bit sets direction of one line pair, 1 output.
// R02: Supplier keeps all pair direction bits zero while lines run bidirectional.
// R03: Serial mode: upper eight bits pick push-pull or open drain per pair.
// R04: Serial mode: lower eight bits set direction of pairs 15:14 down to 1:0.
// R05: Host bus mode: bit 2 sets byte enable pin polarity, mux/demux only.
// R06: Host bus mode: bit 1 chooses posted or non-posted internal write.
// R07: Host bus mode: bit 0 chooses normal or delayed read ack removal.
// R08: Config word read-only on both sides, resets to zero, loadable from EEPROM.
// R09: Network mask bit one passes matching network event into frame event field.
// R10: Network mask writable from network, read-only from host, resets zero.
// R11: Application mask bit one routes matching application event to interrupt.
// R12: Application mask writable from host, read-only from network, resets 00ffff0f.
// R13: Multi-byte registers put least significant byte at lowest address.
// R14: Config word meaning follows the currently selected interface mode.
// R15: Interrupt asserted while any request and mask bit pair are both one.
// R16: Frame event indication set while masked network requests are nonzero.
`timescale 1ns/1ns
`include "eicfg_regs.svh"
module eicfg_event_bank (
  input  wire logic                   clk_sys,
  input  wire logic                   resetn,
  input  wire eicfg_pkg::eicfg_mode_t iface_mode,
  input  wire logic                   eeprom_load,
  input  wire logic [15:0]            eeprom_cfg,
  input  wire logic [15:0]            net_addr,
  input  wire logic                   net_wr,
  input  wire logic                   net_rd,
  input  wire logic [7:0]             net_wdata,
  output logic      [7:0]             net_rdata,
  input  wire logic [15:0]            host_addr,
  input  wire logic                   host_wr,
  input  wire logic                   host_rd,
  input  wire logic [7:0]             host_wdata,
  output logic      [7:0]             host_rdata,
  input  wire logic [15:0]            net_event_req,
  input  wire logic [31:0]            app_event_req,
  input  wire logic                   irq_active_high,
  output logic      [15:0]            frame_event_field,
  output logic                        frame_event,
  output logic                        host_irq,
  output logic      [31:0]            io_dir,
  output logic      [15:0]            io_open_drain,
  output logic                        be_active_high,
  output logic                        write_non_posted,
  output logic                        read_ack_delayed
);

  // ********************************************
  // Register byte map
  // ********************************************

  // Byte view of the register space, least significant byte lowest
  function automatic logic [7:0] read_byte(input logic [15:0] a, input logic [15:0] cfg,
                                           input logic [15:0] nm, input logic [31:0] am);
    logic [7:0] r;
    r = 8'h00;
    if (a[15:1] == `EICFG_EXT_CFG_OFS >> 1) begin
      r = a[0] ? cfg[15:8] : cfg[7:0]; // R13
    end else if (a[15:1] == `EICFG_NET_MASK_OFS >> 1) begin
      r = a[0] ? nm[15:8] : nm[7:0]; // R13
    end else if (a[15:2] == `EICFG_APP_MASK_OFS >> 2) begin
      r = am[8*a[1:0] +: 8]; // R13
    end
    return r;
  endfunction

  function automatic logic in_net_mask(input logic [15:0] a);
    return a[15:1] == `EICFG_NET_MASK_OFS >> 1;
  endfunction

  function automatic logic in_app_mask(input logic [15:0] a);
    return a[15:2] == `EICFG_APP_MASK_OFS >> 2;
  endfunction

  // ********************************************
  // Register state
  // ********************************************

  logic [15:0] ext_cfg_q;
  logic [15:0] ext_cfg_d;
  logic [15:0] net_mask_q;
  logic [15:0] net_mask_d;
  logic [31:0] app_mask_q;
  logic [31:0] app_mask_d;
  logic [7:0]  net_rdata_q;
  logic [7:0]  net_rdata_d;
  logic [7:0]  host_rdata_q;
  logic [7:0]  host_rdata_d;

  always_comb begin
    ext_cfg_d    = ext_cfg_q;
    net_mask_d   = net_mask_q;
    app_mask_d   = app_mask_q;
    net_rdata_d  = net_rdata_q;
    host_rdata_d = host_rdata_q;
    // Neither side can write the config word; only the EEPROM loader can
    if (eeprom_load) begin
      ext_cfg_d = eeprom_cfg; // R08
    end
    // Network side owns the network mask; host writes there are dropped
    if (net_wr && in_net_mask(net_addr)) begin
      net_mask_d[8*net_addr[0] +: 8] = net_wdata; // R10 R13
    end
    // Host side owns the application mask; network writes are dropped
    if (host_wr && in_app_mask(host_addr)) begin
      app_mask_d[8*host_addr[1:0] +: 8] = host_wdata; // R12 R13
    end
    // Read data is the value before any write of the same cycle
    if (net_rd) begin
      net_rdata_d = read_byte(net_addr, ext_cfg_q, net_mask_q, app_mask_q);
    end
    if (host_rd) begin
      host_rdata_d = read_byte(host_addr, ext_cfg_q, net_mask_q, app_mask_q);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ext_cfg_q    <= `EICFG_EXT_CFG_RST; // R08
      net_mask_q   <= `EICFG_NET_MASK_RST; // R10
      app_mask_q   <= `EICFG_APP_MASK_RST; // R12
      net_rdata_q  <= 8'h00;
      host_rdata_q <= 8'h00;
    end else begin
      ext_cfg_q    <= ext_cfg_d;
      net_mask_q   <= net_mask_d;
      app_mask_q   <= app_mask_d;
      net_rdata_q  <= net_rdata_d;
      host_rdata_q <= host_rdata_d;
    end
  end

  assign net_rdata  = net_rdata_q;
  assign host_rdata = host_rdata_q;

  // ********************************************
  // Event routing
  // ********************************************

  logic [15:0] field_q;
  logic [15:0] field_d;
  logic        frame_ev_q;
  logic        frame_ev_d;
  logic        irq_q;
  logic        irq_d;

  always_comb begin
    field_d    = net_event_req & net_mask_q; // R09
    frame_ev_d = |field_d; // R16
    // Polarity applied here so the pin flop drives the final level
    irq_d      = (|(app_event_req & app_mask_q)) ~^ irq_active_high; // R11 R15
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      field_q    <= 16'h0000;
      frame_ev_q <= 1'b0;
      irq_q      <= 1'b1;
    end else begin
      field_q    <= field_d;
      frame_ev_q <= frame_ev_d;
      irq_q      <= irq_d;
    end
  end

  assign frame_event_field = field_q;
  assign frame_event       = frame_ev_q;
  assign host_irq          = irq_q;

  // ********************************************
  // Mode dependent configuration outputs
  // ********************************************

  eicfg_dec_if dec_bus ();

  assign dec_bus.mode = iface_mode;
  assign dec_bus.cfg  = ext_cfg_q;

  eicfg_mode_decode u_decode (
    .d (dec_bus.dec)
  );

  logic [31:0] io_dir_q;
  logic [15:0] io_od_q;
  logic        be_pol_q;
  logic        nonpost_q;
  logic        ack_dly_q;

  // R02 is left to the supplier; no gating against bidirectional use here
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      io_dir_q  <= 32'h0000_0000;
      io_od_q   <= 16'h0000;
      be_pol_q  <= 1'b0;
      nonpost_q <= 1'b0;
      ack_dly_q <= 1'b0;
    end else begin
      io_dir_q  <= dec_bus.io_dir; // R01 R04
      io_od_q   <= dec_bus.io_open_drain; // R03
      be_pol_q  <= dec_bus.be_active_high; // R05
      nonpost_q <= dec_bus.write_non_posted; // R06
      ack_dly_q <= dec_bus.read_ack_delayed; // R07
    end
  end

  assign io_dir           = io_dir_q;
  assign io_open_drain    = io_od_q;
  assign be_active_high   = be_pol_q;
  assign write_non_posted = nonpost_q;
  assign read_ack_delayed = ack_dly_q;

  // ********************************************
  // Checks
  // ********************************************

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  a_cfg_read_only: assert property ( // R08
    !eeprom_load |=> $stable(ext_cfg_q)
  ) else $error("config word changed without EEPROM load");

  a_cfg_eeprom_load: assert property ( // R08
    eeprom_load |=> ext_cfg_q == $past(eeprom_cfg)
  ) else $error("EEPROM load not taken");

  a_net_mask_write: assert property ( // R10
    net_wr && net_addr == `EICFG_NET_MASK_OFS + 16'h0001
    |=> net_mask_q[15:8] == $past(net_wdata)
  ) else $error("network mask high byte not written");

  a_net_mask_host_ro: assert property ( // R10
    !(net_wr && in_net_mask(net_addr)) |=> $stable(net_mask_q)
  ) else $error("network mask changed without network write");

  a_app_mask_net_ro: assert property ( // R12
    !(host_wr && in_app_mask(host_addr)) |=> $stable(app_mask_q)
  ) else $error("application mask changed without host write");

  a_app_byte_order: assert property ( // R13
    net_rd && net_addr == `EICFG_APP_MASK_OFS + 16'h0002
    |=> net_rdata_q == $past(app_mask_q[23:16])
  ) else $error("application mask byte lane wrong");

  a_frame_event: assert property ( // R16
    ##1 frame_event == $past(|(net_event_req & net_mask_q))
  ) else $error("frame event does not follow masked requests");

  a_host_irq_level: assert property ( // R15
    ##1 host_irq == ($past(|(app_event_req & app_mask_q)) ~^ $past(irq_active_high))
  ) else $error("interrupt level wrong");

  a_par_io_dir: assert property ( // R01
    iface_mode == eicfg_pkg::MODE_PAR_IO |=> io_dir[31:30] == {2{$past(ext_cfg_q[15])}}
  ) else $error("pair direction not taken from bit 15");

  a_serial_od: assert property ( // R03
    iface_mode == eicfg_pkg::MODE_SERIAL
    |=> io_open_drain[15:14] == {2{$past(ext_cfg_q[15])}} && io_dir[31:16] == 16'h0000
  ) else $error("serial buffer type wrong");

  a_index_be_pol: assert property ( // R05
    iface_mode == eicfg_pkg::MODE_HOST_INDEX |=> !be_active_high
  ) else $error("byte enable polarity active outside mux/demux");

  a_app_mask_write: assert property ( // R12
    host_wr && host_addr == `EICFG_APP_MASK_OFS
    |=> app_mask_q[7:0] == $past(host_wdata)
  ) else $error("application mask low byte not written");

  a_net_byte_order: assert property ( // R13
    host_rd && host_addr == `EICFG_NET_MASK_OFS
    |=> host_rdata_q == $past(net_mask_q[7:0])
  ) else $error("network mask byte lane wrong");

  a_field_map: assert property ( // R09
    ##1 frame_event_field == $past(net_event_req & net_mask_q)
  ) else $error("event field does not follow masked requests");

  a_serial_dir: assert property ( // R04
    iface_mode == eicfg_pkg::MODE_SERIAL |=> io_dir[15:14] == {2{$past(ext_cfg_q[7])}}
  ) else $error("serial pair direction not taken from bit 7");

  a_mux_be_pol: assert property ( // R05
    iface_mode inside {eicfg_pkg::MODE_HOST_MUX, eicfg_pkg::MODE_HOST_DEMUX}
    |=> be_active_high == $past(ext_cfg_q[`EICFG_HB_BE_POL_BIT])
  ) else $error("byte enable polarity not taken from config");

  a_write_timing: assert property ( // R06
    iface_mode inside {eicfg_pkg::MODE_HOST_INDEX, eicfg_pkg::MODE_HOST_MUX,
                       eicfg_pkg::MODE_HOST_DEMUX}
    |=> write_non_posted == $past(ext_cfg_q[`EICFG_HB_NONPOST_BIT])
  ) else $error("write timing not taken from config");

  a_ack_delay: assert property ( // R07
    iface_mode inside {eicfg_pkg::MODE_HOST_INDEX, eicfg_pkg::MODE_HOST_MUX,
                       eicfg_pkg::MODE_HOST_DEMUX}
    |=> read_ack_delayed == $past(ext_cfg_q[`EICFG_HB_ACK_DLY_BIT])
  ) else $error("read acknowledge delay not taken from config");

  a_idle_mode_quiet: assert property ( // R14
    !(iface_mode inside {eicfg_pkg::MODE_PAR_IO, eicfg_pkg::MODE_SERIAL})
    |=> io_dir == 32'h0000_0000 && io_open_drain == 16'h0000
  ) else $error("line settings driven outside I/O modes");

endmodule

/* rtl/eicfg_regs.svh */
// Offsets, field positions and reset values of the event mask register bank
`ifndef EICFG_REGS_SVH
`define EICFG_REGS_SVH

`define EICFG_EXT_CFG_OFS    16'h0152
`define EICFG_NET_MASK_OFS   16'h0200
`define EICFG_APP_MASK_OFS   16'h0204

`define EICFG_EXT_CFG_RST    16'h0000
`define EICFG_NET_MASK_RST   16'h0000
`define EICFG_APP_MASK_RST   32'h00ffff0f

`define EICFG_HB_BE_POL_BIT  2
`define EICFG_HB_NONPOST_BIT 1
`define EICFG_HB_ACK_DLY_BIT 0

`endif

/* rtl/eicfg_pkg.sv */
// Types shared by the event mask register bank
package eicfg_pkg;

  // Selected process data interface mode, driven by the interface control register
  typedef enum logic [2:0] {
    MODE_NONE       = 3'h0,
    MODE_PAR_IO     = 3'h1,
    MODE_SERIAL     = 3'h2,
    MODE_HOST_INDEX = 3'h3,
    MODE_HOST_MUX   = 3'h4,
    MODE_HOST_DEMUX = 3'h5
  } eicfg_mode_t;

endpackage

/* rtl/eicfg_dec_if.sv */
// Carrier between the register bank and its configuration word decoder
`timescale 1ns/1ns
interface eicfg_dec_if;
  eicfg_pkg::eicfg_mode_t mode;
  logic [15:0]            cfg;
  logic [31:0]            io_dir;
  logic [15:0]            io_open_drain;
  logic                   be_active_high;
  logic                   write_non_posted;
  logic                   read_ack_delayed;

  modport bank (output mode, output cfg, input io_dir, input io_open_drain,
                input be_active_high, input write_non_posted, input read_ack_delayed);
  modport dec  (input mode, input cfg, output io_dir, output io_open_drain,
                output be_active_high, output write_non_posted, output read_ack_delayed);
endinterface

/* rtl/eicfg_mode_decode.sv */
// Decoder of the extended configuration word for the selected interface mode
`timescale 1ns/1ns
`include "eicfg_regs.svh"
module eicfg_mode_decode (
  eicfg_dec_if.dec d
);

  // Spread one bit per pair of lines over both lines of the pair
  function automatic logic [31:0] pair_spread(input logic [15:0] bits);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 16; i++) begin
      r[2*i]   = bits[i];
      r[2*i+1] = bits[i];
    end
    return r;
  endfunction

  always_comb begin
    d.io_dir           = 32'h0000_0000;
    d.io_open_drain    = 16'h0000;
    d.be_active_high   = 1'b0;
    d.write_non_posted = 1'b0;
    d.read_ack_delayed = 1'b0;
    unique case (d.mode) // R14
      eicfg_pkg::MODE_PAR_IO: begin
        d.io_dir = pair_spread(d.cfg); // R01
      end
      eicfg_pkg::MODE_SERIAL: begin
        d.io_dir        = pair_spread({8'h00, d.cfg[7:0]}); // R04
        d.io_open_drain = 16'(pair_spread({8'h00, d.cfg[15:8]})); // R03
      end
      eicfg_pkg::MODE_HOST_INDEX: begin
        // Byte enable polarity has no meaning in the indexed variant
        d.write_non_posted = d.cfg[`EICFG_HB_NONPOST_BIT]; // R06
        d.read_ack_delayed = d.cfg[`EICFG_HB_ACK_DLY_BIT]; // R07
      end
      eicfg_pkg::MODE_HOST_MUX, eicfg_pkg::MODE_HOST_DEMUX: begin
        d.be_active_high   = d.cfg[`EICFG_HB_BE_POL_BIT]; // R05
        d.write_non_posted = d.cfg[`EICFG_HB_NONPOST_BIT]; // R06
        d.read_ack_delayed = d.cfg[`EICFG_HB_ACK_DLY_BIT]; // R07
      end
      default: begin
      end
    endcase
  end

endmodule

/* sim/eicfg_bus_model.sv */
// Bus master model for the network and host register ports
`timescale 1ns/1ns
module eicfg_bus_model (
  input  wire logic        clk_sys,
  output logic             net_wr,
  output logic             net_rd,
  output logic      [15:0] net_addr,
  output logic      [7:0]  net_wdata,
  input  wire logic [7:0]  net_rdata,
  output logic             host_wr,
  output logic             host_rd,
  output logic      [15:0] host_addr,
  output logic      [7:0]  host_wdata,
  input  wire logic [7:0]  host_rdata
);
  initial begin
    {net_wr, net_rd, host_wr, host_rd} = 4'h0;
    {net_addr, host_addr} = 32'h0;
    {net_wdata, host_wdata} = 16'h0;
  end
  // One access: strobe held over one taking edge; idle edge first avoids double drive
  task automatic acc(input logic h, input logic w, input logic [15:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    #1;
    if (h) begin
      {host_addr, host_wdata, host_wr, host_rd} = {a, d, w, !w};
    end else begin
      {net_addr, net_wdata, net_wr, net_rd} = {a, d, w, !w};
    end
    @(posedge clk_sys);
    #1;
    q = h ? host_rdata : net_rdata;
    // Released lines show the inverse, not the last value
    {host_wr, host_rd, net_wr, net_rd} = 4'h0;
    {host_addr, host_wdata} = ~{host_addr, host_wdata};
    {net_addr, net_wdata} = ~{net_addr, net_wdata};
  endtask
endmodule

/* sim/test_ext_iface_cfg_event_masks.sv */
// Self-checking bench of the event mask register bank
`timescale 1ns/1ns
module test_ext_iface_cfg_event_masks;
  logic                   clk_sys, resetn, eeprom_load, irq_active_high;
  logic                   net_wr, net_rd, host_wr, host_rd, frame_event, host_irq;
  logic                   be_active_high, write_non_posted, read_ack_delayed;
  eicfg_pkg::eicfg_mode_t iface_mode;
  logic [15:0]            eeprom_cfg, net_addr, host_addr, net_event_req;
  logic [15:0]            frame_event_field, io_open_drain, nm, cfg;
  logic [7:0]             net_wdata, net_rdata, host_wdata, host_rdata, q;
  logic [31:0]            app_event_req, io_dir, am;
  int                     fails, comparisons, cycles;

  eicfg_event_bank dut (.clk_sys(clk_sys), .resetn(resetn), .iface_mode(iface_mode),
    .eeprom_load(eeprom_load), .eeprom_cfg(eeprom_cfg), .net_addr(net_addr),
    .net_wr(net_wr), .net_rd(net_rd), .net_wdata(net_wdata), .net_rdata(net_rdata),
    .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .net_event_req(net_event_req),
    .app_event_req(app_event_req), .irq_active_high(irq_active_high),
    .frame_event_field(frame_event_field), .frame_event(frame_event),
    .host_irq(host_irq), .io_dir(io_dir), .io_open_drain(io_open_drain),
    .be_active_high(be_active_high), .write_non_posted(write_non_posted),
    .read_ack_delayed(read_ack_delayed));
  eicfg_bus_model bus (.clk_sys(clk_sys), .net_wr(net_wr), .net_rd(net_rd),
    .net_addr(net_addr), .net_wdata(net_wdata), .net_rdata(net_rdata),
    .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic close_out;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Ceiling well above the roughly 650 cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [50:0] got, input logic [50:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: output %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic h, input logic [15:0] a, input logic [7:0] e);
    bus.acc(h, 1'b0, a, 8'h00, q);
    chk_byte(q, e);
  endtask

  // Expected decoded outputs: {be, non_posted, ack_delay, open_drain, dir}
  function automatic logic [50:0] dec(input logic [2:0] m, input logic [15:0] c);
    logic [31:0] d;
    logic [15:0] o;
    logic [2:0]  h;
    d = 32'h0;
    o = 16'h0;
    h = 3'h0;
    for (int i = 0; i < 16; i++) begin
      if (m == 3'h1 || (m == 3'h2 && i < 8)) d[2*i +: 2] = {2{c[i]}};
      if (m == 3'h2 && i < 8) o[2*i +: 2] = {2{c[i+8]}};
    end
    if (m >= 3'h3 && m <= 3'h5) h = {c[2] & (m != 3'h3), c[1:0]};
    return {h, o, d};
  endfunction

  task automatic check_defaults;
    logic [15:0] a [8] = '{16'h0152, 16'h0153, 16'h0200, 16'h0201,
                           16'h0204, 16'h0205, 16'h0206, 16'h0207};
    logic [7:0]  e [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0f, 8'hff, 8'hff, 8'h00};
    for (int i = 0; i < 16; i++) begin
      rd_chk(i[0], a[i/2], e[i/2]);
    end
    rd_chk(1'b1, 16'h0300, 8'h00);
    $display("test defaults done");
  endtask

  initial begin
    {resetn, eeprom_load, irq_active_high} = 3'b000;
    {eeprom_cfg, net_event_req, app_event_req} = 64'h0;
    iface_mode = eicfg_pkg::MODE_NONE;
    void'($urandom(95));
    repeat (16) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    check_defaults();
    for (int k = 0; k < 12; k++) begin
      nm = (k == 0) ? 16'h0000 : (k == 1) ? 16'hffff : $urandom;
      am = (k == 0) ? 32'h0 : (k == 1) ? 32'hffffffff : $urandom;
      for (int i = 0; i < 4; i++) begin
        if (i < 2) bus.acc(1'b0, 1'b1, 16'h0200 + i, nm[8*i +: 8], q);
        bus.acc(1'b1, 1'b1, 16'h0204 + i, am[8*i +: 8], q);
      end
      // Writes that must be ignored
      bus.acc(1'b1, 1'b1, 16'h0201, ~nm[15:8], q);
      bus.acc(1'b0, 1'b1, 16'h0206, ~am[23:16], q);
      bus.acc(k[0], 1'b1, 16'h0152, 8'h5a, q);
      for (int i = 0; i < 4; i++) begin
        if (i < 2) rd_chk(k[1], 16'h0200 + i, nm[8*i +: 8]);
        rd_chk(k[0], 16'h0204 + i, am[8*i +: 8]);
      end
      rd_chk(k[1], 16'h0152, 8'h00);
      @(posedge clk_sys);
      #1;
      net_event_req = (k == 1) ? 16'h8000 : (k == 0) ? 16'hffff : $urandom;
      app_event_req = (k == 1) ? 32'h80000000 : (k == 0) ? 32'hffffffff : $urandom;
      irq_active_high = $urandom;
      repeat (2) @(posedge clk_sys);
      #1;
      chk_out({35'h0, frame_event_field}, {35'h0, net_event_req & nm});
      chk_out({50'h0, frame_event}, {50'h0, |(net_event_req & nm)});
      chk_out({50'h0, host_irq}, {50'h0, |(app_event_req & am) ^ !irq_active_high});
    end
    $display("test masks and events done");
    for (int k = 0; k < 16; k++) begin
      // Bidirectional lines never selected here, so direction bits are free
      cfg = (k == 1) ? 16'h8000 : $urandom;
      @(posedge clk_sys);
      #1;
      {eeprom_load, eeprom_cfg} = {1'b1, cfg};
      iface_mode = eicfg_pkg::eicfg_mode_t'(k % 8);
      @(posedge clk_sys);
      #1;
      eeprom_load = 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      chk_out({be_active_high, write_non_posted, read_ack_delayed, io_open_drain, io_dir},
              dec(k % 8, cfg));
      rd_chk(k[0], 16'h0152, cfg[7:0]);
      rd_chk(k[1], 16'h0153, cfg[15:8]);
    end
    $display("test mode decode done");
    @(posedge clk_sys);
    #1;
    resetn = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    check_defaults();
    close_out();
  end
endmodule
